// ===== verilog/sac_pkg.sv
// What this block does
// - Select field picks system clock over 2..64 or the dedicated oscillator.
// - One full conversion takes ten conversion periods; eight of them resolve one bit each.
// - Complete flag is set at every conversion end, enable or not.
// - Flag and enable both set raise a request; in sleep it wakes.
// - Converter is powered only while the enable bit is one.
// - Writing start begins a conversion; the bit reads one while busy.
// - At the end: clear busy, set flag, load result register.
// - Clearing busy aborts; partial result fills unresolved bits with last bit.
// - Reset restores registers, powers off, cancels any conversion.
// - Conversion continues in sleep only with the dedicated oscillator.
// - With the oscillator, the start waits one extra instruction cycle.
// - Sleep with request disabled powers off after completion, enable stays.
// - Sleep with a system-clock source aborts and powers off, enable stays.
// - Compare trigger sets busy, starts a conversion, and clears its timer.
// - Each result is stored in one readable result register.
// - Channel codes 0 to 10 pick inputs, 15 the fixed reference.
`default_nettype none
package sac_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_CFG  = 3'h1;
  localparam logic [2:0] OFS_FLAG = 3'h2;
  localparam logic [2:0] OFS_IEN  = 3'h3;
  localparam logic [2:0] OFS_RES  = 3'h4;
  localparam int unsigned FLAG_POS = 0;
  localparam int unsigned IEN_POS  = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] RES_RST  = 8'h00;
  localparam logic [1:0] SEL_OSC  = 2'h3;
  localparam int unsigned PRES_W  = 6;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned INSTR_CYCLE_NS = 40;
  localparam int unsigned INSTR_CYC =
    (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXTRA_PERIODS = 2;

  typedef struct packed {
    logic [1:0] rsvd;
    logic [3:0] channel_select;
    logic       busy;
    logic       converter_on;
  } sac_ctrl_t;

  typedef struct packed {
    logic       rsvd_hi;
    logic [2:0] conv_clock_select;
    logic [1:0] rsvd_lo;
    logic [1:0] pos_reference_select;
  } sac_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_CONV
  } sac_state_t;
endpackage
`default_nettype wire

// ===== verilog/sac_conv_ctrl.sv
`default_nettype none
module sac_conv_ctrl #(
  parameter int unsigned RES_W = 8
) (
  input  wire logic                    core_clk_i,     // System clock
  input  wire logic                    arst_n_i,       // Async reset
  input  wire logic [sac_pkg::ADDR_W-1:0] reg_addr_i,  // Register index
  input  wire logic [7:0]              reg_wdata_i,    // Write data
  input  wire logic                    reg_wr_i,       // Write strobe
  input  wire logic                    reg_rd_i,       // Read strobe
  output logic      [7:0]              reg_rdata_o,    // Read data
  input  wire logic                    sleep_i,        // Core asleep
  input  wire logic                    frc_tick_i,     // Oscillator pulse
  input  wire logic                    special_trig_i, // Compare trigger
  input  wire logic                    cmp_high_i,     // Input >= trial
  output logic                         timer_clear_o,  // Clear timer
  output logic                         conv_power_o,   // Analog power
  output logic                         sample_hold_o,  // Hold sample
  output logic      [RES_W-1:0]        dac_code_o,     // Trial code
  output logic      [3:0]              channel_o,      // Channel mux
  output logic      [1:0]              pos_ref_sel_o,  // Reference mux
  output logic                         irq_o,          // Request
  output logic                         wake_o          // Wake from sleep
);

  localparam int unsigned PERIODS = RES_W + sac_pkg::EXTRA_PERIODS;

  if (RES_W < 2 || RES_W > 8) begin : g_res_w_chk
    $error("RES_W must lie between 2 and 8");
  end
  if (sac_pkg::INSTR_CYC != 4) begin : g_instr_chk
    $error("Instruction delay must be four cycles");
  end

  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  sac_pkg::sac_ctrl_t  ctl;
  sac_pkg::sac_ctrl_t  ctl_w;
  sac_pkg::sac_cfg_t   cfg;
  sac_pkg::sac_state_t state;
  logic                flag;
  logic                ien;
  logic [7:0]          result;
  logic [RES_W-1:0]    sar;
  logic                last_bit;
  logic [3:0]          period;
  logic [2:0]          wait_cnt;
  logic [sac_pkg::PRES_W-1:0] pres;
  logic [sac_pkg::PRES_W-1:0] pres_mask;
  logic                sleep_off;
  logic                wr_ctl;
  logic                is_osc;
  logic                pres_tick;
  logic                tad_tick;
  logic                sleep_block;
  logic                sw_start;
  logic                hw_start;
  logic                start;
  logic                sw_abort;
  logic                cancel;
  logic                done;
  logic [RES_W-1:0]    partial;

  assign ctl_w  = sac_pkg::sac_ctrl_t'(reg_wdata_i);
  assign wr_ctl = reg_wr_i && (reg_addr_i == sac_pkg::OFS_CTRL);
  assign is_osc = (cfg.conv_clock_select[1:0] == sac_pkg::SEL_OSC);

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  // Division is 2 to the power 2*sel[1:0]+1+sel[2]. The prescaler never
  // stops, so the first period after a start may be short by up to one
  // division; the setup period absorbs it before any bit is resolved.
  always_comb begin
    case (cfg.conv_clock_select)
      3'b000:  pres_mask = 6'h01;
      3'b100:  pres_mask = 6'h03;
      3'b001:  pres_mask = 6'h07;
      3'b101:  pres_mask = 6'h0F;
      3'b010:  pres_mask = 6'h1F;
      default: pres_mask = 6'h3F;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pres <= '0;
    end else begin
      pres <= pres + 1'b1;
    end
  end

  assign pres_tick = ((pres & pres_mask) == pres_mask);
  assign tad_tick  = is_osc ? frc_tick_i : pres_tick;

  // ****************************************************************
  // Start, abort and completion
  // ****************************************************************
  assign sleep_block = sleep_i && !is_osc;
  assign sw_start = wr_ctl && ctl_w.busy && ctl_w.converter_on
                    && ctl.converter_on && !ctl.busy;
  assign hw_start = special_trig_i && ctl.converter_on
                    && !ctl.busy;
  // A trigger that meets a disabling write must not start on a dead module.
  assign start    = (sw_start || hw_start) && !sleep_block && !cancel;
  assign sw_abort = wr_ctl && ctl_w.converter_on && !ctl_w.busy
                    && ctl.busy;
  assign cancel   = (wr_ctl && !ctl_w.converter_on)
                    || (sleep_block && ctl.busy);
  assign done     = (state == sac_pkg::ST_CONV) && tad_tick
                    && (period == 4'(PERIODS - 1)) && !sw_abort
                    && !cancel;

  // Unresolved bits copy the last resolved one. Bits resolved so far are
  // those at and above RES_W-(period-1).
  always_comb begin
    partial = '0;
    for (int i = 0; i < RES_W; i++) begin
      if (period >= 4'd2 && i >= RES_W + 1 - int'(period)) begin
        partial[i] = sar[i];
      end else if (period >= 4'd2) begin
        partial[i] = last_bit;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= sac_pkg::ST_IDLE;
      wait_cnt <= '0;
    end else begin
      case (state)
        sac_pkg::ST_IDLE: begin
          if (start && is_osc) begin
            state    <= sac_pkg::ST_WAIT;
            wait_cnt <= 3'(sac_pkg::INSTR_CYC - 1);
          end else if (start) begin
            state <= sac_pkg::ST_CONV;
          end
        end
        sac_pkg::ST_WAIT: begin
          if (sw_abort || cancel) begin
            state <= sac_pkg::ST_IDLE;
          end else if (wait_cnt == '0) begin
            state <= sac_pkg::ST_CONV;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        sac_pkg::ST_CONV: begin
          if (sw_abort || cancel || done) begin
            state <= sac_pkg::ST_IDLE;
          end
        end
        default: state <= sac_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Successive approximation
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sar      <= '0;
      period   <= '0;
      last_bit <= 1'b0;
    end else if (state != sac_pkg::ST_CONV) begin
      sar    <= '0;
      period <= '0;
    end else if (tad_tick) begin
      period <= period + 1'b1;
      if (period == 4'd0) begin
        sar[RES_W-1] <= 1'b1;
      end else if (period <= 4'(RES_W)) begin
        sar[RES_W-int'(period)] <= cmp_high_i;
        last_bit <= cmp_high_i;
        if (period < 4'(RES_W)) begin
          sar[RES_W-1-int'(period)] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctl <= sac_pkg::sac_ctrl_t'(sac_pkg::CTRL_RST);
    end else begin
      if (wr_ctl) begin
        ctl.channel_select <= ctl_w.channel_select;
        ctl.converter_on   <= ctl_w.converter_on;
        ctl.busy <= ctl_w.busy && ctl.busy && ctl_w.converter_on;
      end
      if (start) begin
        ctl.busy <= 1'b1;
      end else if (done || cancel) begin
        ctl.busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= sac_pkg::sac_cfg_t'(sac_pkg::CFG_RST);
      ien <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == sac_pkg::OFS_CFG) begin
      cfg <= sac_pkg::sac_cfg_t'(reg_wdata_i);
    end else if (reg_wr_i && reg_addr_i == sac_pkg::OFS_IEN) begin
      ien <= reg_wdata_i[sac_pkg::IEN_POS];
    end
  end

  // The hardware set beats a software clear in the same cycle.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag <= 1'b0;
    end else if (done) begin
      flag <= 1'b1;
    end else if (reg_wr_i && reg_addr_i == sac_pkg::OFS_FLAG) begin
      flag <= reg_wdata_i[sac_pkg::FLAG_POS];
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      result <= sac_pkg::RES_RST;
    end else if (done) begin
      result <= 8'(sar);
    end else if (sw_abort && state == sac_pkg::ST_CONV) begin
      result <= 8'(partial);
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= '0;
    end else if (!reg_rd_i) begin
      reg_rdata_o <= '0;
    end else if (reg_addr_i == sac_pkg::OFS_CTRL) begin
      reg_rdata_o <= ctl;
    end else if (reg_addr_i == sac_pkg::OFS_CFG) begin
      reg_rdata_o <= cfg;
    end else if (reg_addr_i == sac_pkg::OFS_FLAG) begin
      reg_rdata_o <= {7'h00, flag};
    end else if (reg_addr_i == sac_pkg::OFS_IEN) begin
      reg_rdata_o <= {7'h00, ien};
    end else if (reg_addr_i == sac_pkg::OFS_RES) begin
      reg_rdata_o <= result;
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ****************************************************************
  // Power, sleep and outputs
  // ****************************************************************
  // The enable bit keeps reading as set while sleep holds power down.
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sleep_off <= 1'b0;
    end else if (!sleep_i) begin
      sleep_off <= 1'b0;
    end else if (sleep_block) begin
      sleep_off <= 1'b1;
    end else if (done && !ien) begin
      sleep_off <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      conv_power_o  <= 1'b0;
      sample_hold_o <= 1'b0;
      dac_code_o    <= '0;
      channel_o     <= '0;
      pos_ref_sel_o <= '0;
      timer_clear_o <= 1'b0;
      irq_o         <= 1'b0;
      wake_o        <= 1'b0;
    end else begin
      conv_power_o  <= ctl.converter_on && !sleep_off;
      sample_hold_o <= (state == sac_pkg::ST_CONV);
      dac_code_o    <= sar;
      channel_o     <= ctl.channel_select;
      pos_ref_sel_o <= cfg.pos_reference_select;
      timer_clear_o <= special_trig_i;
      irq_o         <= flag && ien;
      wake_o        <= flag && ien && sleep_i;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [3:0] a_ticks;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      a_ticks <= '0;
    end else if (start) begin
      a_ticks <= '0;
    end else if (state == sac_pkg::ST_CONV && tad_tick) begin
      a_ticks <= a_ticks + 1'b1;
    end
  end

  sequence s_osc_start;
    start && is_osc && state == sac_pkg::ST_IDLE;
  endsequence

  sequence s_osc_wait;
    (state == sac_pkg::ST_WAIT && !sw_abort && !cancel) [*4];
  endsequence

  a_ten_periods: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) done |-> a_ticks == 4'(PERIODS - 1))
    else $error("conversion did not take ten periods");
  a_done_effects: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) done |=> flag && !ctl.busy
      && result == 8'($past(sar)))
    else $error("completion effects missing");
  a_flag_kept: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    flag && !(reg_wr_i && reg_addr_i == sac_pkg::OFS_FLAG) |=> flag)
    else $error("complete flag cleared by hardware");
  a_irq_wake: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) flag && ien && sleep_i |=> irq_o && wake_o)
    else $error("request or wake missing");
  a_osc_delay: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    s_osc_start ##1 s_osc_wait |=> state == sac_pkg::ST_CONV)
    else $error("oscillator start delay wrong");
  a_off_ignores: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    !ctl.converter_on && state == sac_pkg::ST_IDLE |=> !ctl.busy
      && result == $past(result))
    else $error("start accepted while disabled");
  a_sleep_abort: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    sleep_block && ctl.busy |=> !ctl.busy ##1 !conv_power_o)
    else $error("sleep did not abort conversion");
  a_trig_timer: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    hw_start && start |=> timer_clear_o && ctl.busy)
    else $error("trigger did not start and clear timer");
  a_power_gate: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) conv_power_o |-> $past(ctl.converter_on))
    else $error("converter powered while disabled");

endmodule
`default_nettype wire

// ===== dv/sac_analog_model.sv
`default_nettype none
module sac_analog_model #(
  parameter int unsigned FRC_DIV = 8 // Oscillator period in clocks
) (
  input  wire logic       clk_i,   // System clock
  input  wire logic       rst_n_i, // Async reset
  input  wire logic [7:0] dac_i,   // Trial code
  input  wire logic       power_i, // Analog power
  input  wire logic [7:0] level_i, // Input level in codes
  output logic            cmp_o,   // Input >= trial
  output logic            tick_o   // Oscillator pulse
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned cnt;
  logic        junk;
  // An unpowered comparator decides nothing, so a toggling level keeps
  // the design from leaning on a stale answer.
  assign cmp_o = power_i ? (level_i >= dac_i) : junk;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      junk <= 1'b0;
      tick_o <= 1'b0;
    end else begin
      junk <= !junk;
      cnt <= (cnt == FRC_DIV - 1) ? 0 : cnt + 1;
      tick_o <= (cnt == FRC_DIV - 1);
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TIMEOUT = 20000;
  logic       clk, arst_n, wr, rd, slp, trig, cmp, frc;
  logic       tclr, pwr, sh, irq, wake;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, dac, level, d;
  logic [3:0] chan;
  logic [1:0] pref;
  logic [2:0] sel [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
  int         miscompares = 0;
  int         tests_run = 0;
  int         cycles = 0;
  int         hl = 0;
  int         last_len = 0;
  int         dl;
  int         dv;

  sac_conv_ctrl uut (
    .core_clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .sleep_i(slp), .frc_tick_i(frc),
    .special_trig_i(trig), .cmp_high_i(cmp), .timer_clear_o(tclr),
    .conv_power_o(pwr), .sample_hold_o(sh), .dac_code_o(dac),
    .channel_o(chan), .pos_ref_sel_o(pref), .irq_o(irq), .wake_o(wake));
  sac_analog_model ana (
    .clk_i(clk), .rst_n_i(arst_n), .dac_i(dac), .power_i(pwr),
    .level_i(level), .cmp_o(cmp), .tick_o(frc));

  // ********************
  // Clock and monitors
  // ********************
  initial clk = 1'b0;
  always #5 clk = !clk;
  always @(posedge clk) begin
    cycles++;
    if (sh === 1'b1) hl++;
    else if (hl != 0) begin
      last_len = hl;
      hl = 0;
    end
    if (cycles == TIMEOUT) begin
      miscompares++;
      $display("wrong value cycle limit: expected below %0d, seen %0d",
               TIMEOUT, cycles);
      end_of_test;
    end
  end

  // ********************
  // Tasks
  // ********************
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe.
  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic start(input logic [7:0] v);
    wreg(sac_pkg::OFS_CTRL, v);
    dl = 0;
    while (sh !== 1'b1 && dl < 100) begin
      @(negedge clk);
      dl++;
    end
    @(posedge clk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    d = 8'h02;
    while (d[1] !== 1'b0 && n < 1000) begin
      rreg(sac_pkg::OFS_CTRL, d);
      n++;
    end
    if (n >= 1000) chk("busy end", 8'h00, 8'h01);
    // The hold-length monitor updates two edges after busy drops.
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse_trig;
    @(posedge clk);
    trig <= 1'b1;
    @(posedge clk);
    trig <= 1'b0;
    @(negedge clk);
    chk("timer clear", 8'h01, tclr);
  endtask
  task end_of_test;
    $display("%0d compares, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    {arst_n, wr, rd, slp, trig, addr, wdata} = '0;
    level = 8'h00;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rreg(a[2:0], d);
      chk("reset read", 8'h00, d);
    end
    wreg(sac_pkg::OFS_CTRL, 8'h02);
    rreg(sac_pkg::OFS_CTRL, d);
    chk("start while off", 8'h00, d);
    chk("power off", 8'h00, pwr);
    wreg(sac_pkg::OFS_CTRL, 8'h3D);
    wreg(sac_pkg::OFS_CFG, 8'h02);
    // The reference output follows its register one edge later.
    repeat (2) @(negedge clk);
    chk("power on", 8'h01, pwr);
    chk("channel", 8'h0F, chan);
    chk("reference", 8'h02, pref);
    for (int i = 0; i < 6; i++) begin
      dv = 2 << i;
      wreg(sac_pkg::OFS_CFG, {1'b0, sel[i], 4'h2});
      level <= 8'h5A + 8'(i * 37);
      start(8'h3F);
      rreg(sac_pkg::OFS_CTRL, d);
      chk("busy bit", 8'h3F, d);
      wait_idle;
      chk("period count", 8'h01,
          (last_len >= 9 * dv && last_len <= 10 * dv + 1));
      rreg(sac_pkg::OFS_RES, d);
      chk("result", level, d);
      rreg(sac_pkg::OFS_FLAG, d);
      chk("flag", 8'h01, d);
      wreg(sac_pkg::OFS_FLAG, 8'h00);
    end
    wreg(sac_pkg::OFS_CFG, 8'h02);
    wreg(sac_pkg::OFS_IEN, 8'h01);
    start(8'h3F);
    wait_idle;
    repeat (40) @(posedge clk);
    chk("irq", 8'h01, irq);
    chk("wake awake", 8'h00, wake);
    rreg(sac_pkg::OFS_FLAG, d);
    chk("flag kept", 8'h01, d);
    wreg(sac_pkg::OFS_FLAG, 8'h00);
    wreg(sac_pkg::OFS_IEN, 8'h00);
    chk("irq cleared", 8'h00, irq);
    // Four or five resolved bits of 0x3F fill out to 0x3F.
    wreg(sac_pkg::OFS_CFG, 8'h62);
    level <= 8'h3F;
    start(8'h3F);
    repeat (320) @(posedge clk);
    wreg(sac_pkg::OFS_CTRL, 8'h3D);
    rreg(sac_pkg::OFS_RES, d);
    chk("partial result", 8'h3F, d);
    rreg(sac_pkg::OFS_FLAG, d);
    chk("abort flag", 8'h00, d);
    level <= 8'h81;
    wreg(sac_pkg::OFS_CFG, 8'h02);
    pulse_trig;
    rreg(sac_pkg::OFS_CTRL, d);
    chk("trigger busy", 8'h3F, d);
    wait_idle;
    rreg(sac_pkg::OFS_RES, d);
    chk("trigger result", 8'h81, d);
    wreg(sac_pkg::OFS_FLAG, 8'h00);
    wreg(sac_pkg::OFS_CTRL, 8'h3C);
    pulse_trig;
    rreg(sac_pkg::OFS_CTRL, d);
    chk("trigger while off", 8'h3C, d);
    wreg(sac_pkg::OFS_CTRL, 8'h3D);
    wreg(sac_pkg::OFS_CFG, 8'h62);
    start(8'h3F);
    slp <= 1'b1;
    repeat (4) @(posedge clk);
    chk("sleep power", 8'h00, pwr);
    rreg(sac_pkg::OFS_CTRL, d);
    chk("sleep abort", 8'h3D, d);
    slp <= 1'b0;
    repeat (3) @(posedge clk);
    chk("power back", 8'h01, pwr);
    rreg(sac_pkg::OFS_FLAG, d);
    chk("sleep flag", 8'h00, d);
    wreg(sac_pkg::OFS_CFG, 8'h32);
    wreg(sac_pkg::OFS_IEN, 8'h01);
    level <= 8'h77;
    start(8'h3F);
    chk("start delay", 8'h01, (dl == 2 + sac_pkg::INSTR_CYC));
    slp <= 1'b1;
    wait_idle;
    chk("wake", 8'h01, wake);
    rreg(sac_pkg::OFS_RES, d);
    chk("sleep result", 8'h77, d);
    slp <= 1'b0;
    wreg(sac_pkg::OFS_FLAG, 8'h00);
    wreg(sac_pkg::OFS_IEN, 8'h00);
    wreg(sac_pkg::OFS_CFG, 8'h72);
    level <= 8'hC3;
    wreg(sac_pkg::OFS_CTRL, 8'h3F);
    slp <= 1'b1;
    wait_idle;
    repeat (2) @(posedge clk);
    chk("done power", 8'h00, pwr);
    chk("no wake", 8'h00, wake);
    rreg(sac_pkg::OFS_CTRL, d);
    chk("on kept", 8'h3D, d);
    rreg(sac_pkg::OFS_RES, d);
    chk("osc result", 8'hC3, d);
    slp <= 1'b0;
    wreg(sac_pkg::OFS_CFG, 8'h62);
    start(8'h3F);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk("reset power", 8'h00, pwr);
    rreg(sac_pkg::OFS_CTRL, d);
    chk("reset ctrl", sac_pkg::CTRL_RST, d);
    rreg(sac_pkg::OFS_RES, d);
    chk("reset result", sac_pkg::RES_RST, d);
    end_of_test;
  end
endmodule
`default_nettype wire
